// >>> logic/vicsr_pkg.sv
package vicsr_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ = 4'h2;
  localparam logic [3:0] ADDR_USED = 4'h3;
  localparam logic [3:0] ADDR_SAMP = 4'h4;
  localparam logic [3:0] ADDR_LINE = 4'h5;
  localparam int CTRL_GO = 0;
  localparam int CTRL_UPD_EN = 1;
  localparam int CTRL_STB_EN = 2;
  localparam int CTRL_SYNC_EN = 3;
  localparam int ST_RUN = 0;
  localparam int ST_SAMP_OK = 3;
  localparam int ST_F0_OK = 4;
  localparam int ST_F1_OK = 6;
  localparam int ST_INTL = 7;
  localparam int ST_STABLE = 8;
  localparam int ST_OVF = 9;
  localparam int ST_RES = 10;
  localparam int IRQ_UPD = 1;
  localparam int IRQ_STB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

// >>> logic/vicsr_run_if.sv
`timescale 1ns/1ns
interface vicsr_run_if;
  logic go;
  logic frame_start;
  logic running;
  modport ctl(output go, output frame_start, input running);
  modport seq(input go, input frame_start, output running);
endinterface

// >>> logic/vicsr_run_seq.sv
`timescale 1ns/1ns
module vicsr_run_seq (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  vicsr_run_if.seq run
);
  // ---------------------------------------------
  // Start and stop only on frame boundaries
  // ---------------------------------------------
  logic running;
  logic next_running;

  always_comb begin
    next_running = running;
    if (run.frame_start) begin
      next_running = run.go;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      running <= 1'h0;
    end else begin
      running <= next_running;
    end
  end

  assign run.running = running;

  AST_RUN_AT_BOUNDARY: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !run.frame_start |=> running == $past(running))
    else $error("Run state changed off frame boundary");
  AST_RUN_FOLLOWS_GO: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    run.frame_start |=> running == $past(run.go))
    else $error("Run state did not follow go at boundary");
endmodule

// >>> logic/vicsr_top.sv
`timescale 1ns/1ns
module vicsr_top #(
  parameter int DATA_W = 32,
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [DATA_W-1:0] av_writedata_i,
  output logic [DATA_W-1:0] av_readdata_o,
  input wire logic frame_start_i,
  input wire logic samples_valid_i,
  input wire logic f0_valid_i,
  input wire logic f1_valid_i,
  input wire logic interlaced_i,
  input wire logic stable_i,
  input wire logic overflow_i,
  input wire logic resolution_valid_i,
  input wire logic status_update_i,
  input wire logic [COUNT_W-1:0] fifo_used_i,
  input wire logic [COUNT_W-1:0] active_samples_i,
  input wire logic [COUNT_W-1:0] first_field_lines_i,
  input wire logic sof_i,
  input wire logic sof_locked_i,
  input wire logic refclk_div_i,
  output logic running_o,
  output logic sof_o,
  output logic sof_locked_o,
  output logic refclk_div_o,
  output logic irq_o
);
  // ---------------------------------------------
  // Control register and run sequencer
  // ---------------------------------------------
  vicsr_run_if run ();

  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_irq;

  assign wr_ctrl = av_write_i && av_address_i == vicsr_pkg::ADDR_CTRL;
  assign wr_stat = av_write_i && av_address_i == vicsr_pkg::ADDR_STAT;
  assign wr_irq = av_write_i && av_address_i == vicsr_pkg::ADDR_IRQ;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = av_writedata_i[3:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= vicsr_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  assign run.go = ctrl[vicsr_pkg::CTRL_GO];
  assign run.frame_start = frame_start_i;

  vicsr_run_seq vicsr_run_seq_i (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run(run.seq)
  );

  // ---------------------------------------------
  // Sticky overflow and interrupt status
  // ---------------------------------------------
  logic ovf;
  logic next_ovf;
  logic [1:0] pend;
  logic [1:0] next_pend;
  logic stable_q;
  logic upd_ev;
  logic stb_ev;

  // Stable event on rising edge of stable indication
  assign stb_ev = stable_i && !stable_q;
  assign upd_ev = status_update_i;

  always_comb begin
    next_ovf = ovf;
    if (wr_stat && av_writedata_i[vicsr_pkg::ST_OVF]) begin
      next_ovf = 1'h0;
    end
    if (overflow_i) begin
      next_ovf = 1'h1;
    end
    next_pend = pend;
    if (wr_irq) begin
      next_pend = pend & ~{av_writedata_i[vicsr_pkg::IRQ_STB],
                           av_writedata_i[vicsr_pkg::IRQ_UPD]};
    end
    if (upd_ev && ctrl[vicsr_pkg::CTRL_UPD_EN]) begin
      next_pend[0] = 1'h1;
    end
    if (stb_ev && ctrl[vicsr_pkg::CTRL_STB_EN]) begin
      next_pend[1] = 1'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf <= 1'h0;
      pend <= vicsr_pkg::IRQ_RESET;
      stable_q <= 1'h0;
    end else begin
      ovf <= next_ovf;
      pend <= next_pend;
      stable_q <= stable_i;
    end
  end

  // ---------------------------------------------
  // Status word and read mux
  // ---------------------------------------------
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    stat_word = '0;
    stat_word[vicsr_pkg::ST_RUN] = run.running;
    stat_word[vicsr_pkg::ST_SAMP_OK] = samples_valid_i;
    stat_word[vicsr_pkg::ST_F0_OK] = f0_valid_i;
    stat_word[vicsr_pkg::ST_F1_OK] = f1_valid_i;
    stat_word[vicsr_pkg::ST_INTL] = interlaced_i;
    stat_word[vicsr_pkg::ST_STABLE] = stable_i;
    stat_word[vicsr_pkg::ST_OVF] = ovf;
    stat_word[vicsr_pkg::ST_RES] = resolution_valid_i;
  end

  always_comb begin
    next_rdata = '0;
    if (av_read_i) begin
      unique case (av_address_i)
        vicsr_pkg::ADDR_CTRL: next_rdata[3:0] = ctrl;
        vicsr_pkg::ADDR_STAT: next_rdata = stat_word;
        vicsr_pkg::ADDR_IRQ: next_rdata[2:1] = pend;
        vicsr_pkg::ADDR_USED: next_rdata[COUNT_W-1:0] = fifo_used_i;
        vicsr_pkg::ADDR_SAMP:
          next_rdata[COUNT_W-1:0] = active_samples_i;
        vicsr_pkg::ADDR_LINE:
          next_rdata[COUNT_W-1:0] = first_field_lines_i;
        default: next_rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------
  // Registered outputs
  // ---------------------------------------------
  logic sync_en;
  assign sync_en = ctrl[vicsr_pkg::CTRL_SYNC_EN];

  logic next_running_o;
  logic next_sof;
  logic next_sof_locked;
  logic next_refclk_div;
  logic next_irq;

  always_comb begin
    next_running_o = run.running;
    next_sof = sync_en && sof_i;
    next_sof_locked = sync_en && sof_locked_i;
    next_refclk_div = sync_en && refclk_div_i;
    next_irq = |(next_pend & ctrl[2:1]);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      av_readdata_o <= '0;
      running_o <= 1'h0;
      sof_o <= 1'h0;
      sof_locked_o <= 1'h0;
      refclk_div_o <= 1'h0;
      irq_o <= 1'h0;
    end else begin
      av_readdata_o <= next_rdata;
      running_o <= next_running_o;
      sof_o <= next_sof;
      sof_locked_o <= next_sof_locked;
      refclk_div_o <= next_refclk_div;
      irq_o <= next_irq;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  AST_SYNC_GATED: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !sync_en |=> !sof_o && !sof_locked_o && !refclk_div_o)
    else $error("Sync output active while disabled");
  AST_OVF_STICKY: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    overflow_i |=> ovf)
    else $error("Overflow not latched");
  AST_OVF_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ovf && !(wr_stat && av_writedata_i[vicsr_pkg::ST_OVF]) |=> ovf)
    else $error("Overflow cleared without write one");
  AST_UPD_SET: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    upd_ev && ctrl[vicsr_pkg::CTRL_UPD_EN] |=> pend[0])
    else $error("Status update pending not set");
  AST_UPD_GATED: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !pend[0] && !ctrl[vicsr_pkg::CTRL_UPD_EN] |=> !pend[0])
    else $error("Status update pending set while disabled");
  AST_STB_SET: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    stable_i && !stable_q && ctrl[vicsr_pkg::CTRL_STB_EN] |=> pend[1])
    else $error("Stable pending not set");
  AST_PEND_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    pend[1] && !wr_irq |=> pend[1])
    else $error("Pending bit lost without write");
  AST_IRQ_OUT: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ##1 irq_o == |(pend & $past(ctrl[2:1])))
    else $error("Interrupt output mismatch");
  AST_READ_USED: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_USED
    |=> av_readdata_o[COUNT_W-1:0] == $past(fifo_used_i))
    else $error("Fill level read wrong");
  AST_STAT_UNUSED: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[1] == 1'h0 && av_readdata_o[2] == 1'h0
        && av_readdata_o[5] == 1'h0)
    else $error("Unused status bits not zero");

  // ---------------------------------------------
  // Status, pending and readback checks
  // ---------------------------------------------
  AST_STAT_RUN: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[vicsr_pkg::ST_RUN] == $past(run.running))
    else $error("Run status bit wrong");
  AST_RUN_OUT: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ##1 running_o == $past(run.running))
    else $error("Running output does not follow run state");
  AST_STAT_VALID: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[vicsr_pkg::ST_SAMP_OK] == $past(samples_valid_i)
        && av_readdata_o[vicsr_pkg::ST_F0_OK] == $past(f0_valid_i)
        && av_readdata_o[vicsr_pkg::ST_F1_OK] == $past(f1_valid_i))
    else $error("Count valid status bits wrong");
  AST_STAT_INTL: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[vicsr_pkg::ST_INTL] == $past(interlaced_i))
    else $error("Interlaced status bit wrong");
  AST_STAT_STABLE: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[vicsr_pkg::ST_STABLE] == $past(stable_i))
    else $error("Stable status bit wrong");
  AST_STAT_OVF: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[vicsr_pkg::ST_OVF] == $past(ovf))
    else $error("Overflow status bit wrong");
  AST_STAT_RES: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_STAT
    |=> av_readdata_o[vicsr_pkg::ST_RES] == $past(resolution_valid_i))
    else $error("Resolution status bit wrong");
  AST_OVF_CLEAR: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_stat && av_writedata_i[vicsr_pkg::ST_OVF] && !overflow_i |=> !ovf)
    else $error("Overflow not cleared by write one");
  AST_STB_GATED: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !pend[1] && !ctrl[vicsr_pkg::CTRL_STB_EN] |=> !pend[1])
    else $error("Stable pending set while disabled");
  AST_IRQ_READ: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_IRQ
    |=> av_readdata_o[2:1] == $past(pend))
    else $error("Pending bits read wrong");
  AST_UPD_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    pend[0] && !wr_irq |=> pend[0])
    else $error("Update pending lost without write");
  AST_UPD_KEEP: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_irq && !av_writedata_i[vicsr_pkg::IRQ_UPD] && pend[0] |=> pend[0])
    else $error("Update pending lost on write zero");
  AST_STB_KEEP: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_irq && !av_writedata_i[vicsr_pkg::IRQ_STB] && pend[1] |=> pend[1])
    else $error("Stable pending lost on write zero");
  AST_UPD_CLEAR: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_irq && av_writedata_i[vicsr_pkg::IRQ_UPD] && !upd_ev |=> !pend[0])
    else $error("Update pending not cleared by write one");
  AST_STB_CLEAR: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_irq && av_writedata_i[vicsr_pkg::IRQ_STB] && !stb_ev |=> !pend[1])
    else $error("Stable pending not cleared by write one");
  AST_READ_SAMP: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_SAMP
    |=> av_readdata_o[COUNT_W-1:0] == $past(active_samples_i))
    else $error("Sample count read wrong");
  AST_READ_LINE: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    av_read_i && av_address_i == vicsr_pkg::ADDR_LINE
    |=> av_readdata_o[COUNT_W-1:0] == $past(first_field_lines_i))
    else $error("Line count read wrong");
  AST_CTRL_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_ctrl |=> ctrl == $past(av_writedata_i[3:0]))
    else $error("Control write not taken");
  AST_CTRL_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !wr_ctrl |=> ctrl == $past(ctrl))
    else $error("Control changed without write");
  AST_SYNC_PASS: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    sync_en |=> sof_o == $past(sof_i)
        && sof_locked_o == $past(sof_locked_i)
        && refclk_div_o == $past(refclk_div_i))
    else $error("Sync output not passed while enabled");

  COV_OVF_CLEAR: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) ovf ##1 !ovf);
  COV_IRQ: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) !irq_o ##1 irq_o);
  COV_RUN: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) !running_o ##1 running_o);
  COV_STB_PEND: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) !pend[1] ##1 pend[1]);
  COV_SYNC: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) !sof_o ##1 sof_o);
endmodule

// >>> verification/tb_video_input_control_status.sv
`timescale 1ns/1ns
module tb_video_input_control_status;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] adr;
  logic rds, wrs, fs, ovf, upd, run, so, sl, rdiv, irq;
  logic [31:0] wd, rdata;
  logic [5:0] lv = 6'h0;
  logic [2:0] sy = 3'h0;
  logic [15:0] used = 16'h0, samp = 16'h0, lines = 16'h0;
  int error_cnt = 0;
  int checked = 0;
  int pos [6] = '{3, 4, 6, 7, 8, 10};
  initial fs = 1'h0;
  initial ovf = 1'h0;
  initial upd = 1'h0;
  always #5 clk = ~clk;
  vicsr_host vicsr_host_i (.sys_clk_i(clk), .av_readdata_i(rdata),
    .av_address_o(adr), .av_read_o(rds), .av_write_o(wrs),
    .av_writedata_o(wd));
  vicsr_top vicsr_top_i (.sys_clk_i(clk), .rst_i(rst),
    .av_address_i(adr), .av_read_i(rds), .av_write_i(wrs),
    .av_writedata_i(wd), .av_readdata_o(rdata), .frame_start_i(fs),
    .samples_valid_i(lv[0]), .f0_valid_i(lv[1]), .f1_valid_i(lv[2]),
    .interlaced_i(lv[3]), .stable_i(lv[4]), .overflow_i(ovf),
    .resolution_valid_i(lv[5]), .status_update_i(upd),
    .fifo_used_i(used), .active_samples_i(samp),
    .first_field_lines_i(lines), .sof_i(sy[2]), .sof_locked_i(sy[1]),
    .refclk_div_i(sy[0]), .running_o(run), .sof_o(so),
    .sof_locked_o(sl), .refclk_div_o(rdiv), .irq_o(irq));
  // ------------------------------
  // Shared helpers
  // ------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    vicsr_host_i.rd(a, d);
    chk(d & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task automatic results();
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    rchk(4'h0, 32'hf, 32'h0);
    rchk(4'h1, 32'hffff_ffff, 32'h0);
    rchk(4'h2, 32'h6, 32'h0);
    rchk(4'h6, 32'hffff_ffff, 32'h0);
    chk({run, so, sl, rdiv, irq}, 32'h0);
  endtask
  task automatic t_go();
    vicsr_host_i.wr(4'h0, 32'h1);
    cyc(3);
    chk(run, 1'h0);
    pulse(fs);
    cyc(2);
    chk(run, 1'h1);
    rchk(4'h1, 32'h1, 32'h1);
    vicsr_host_i.wr(4'h0, 32'h0);
    cyc(3);
    chk(run, 1'h1);
    pulse(fs);
    cyc(2);
    rchk(4'h1, 32'h1, 32'h0);
  endtask
  task automatic t_status();
    for (int i = 0; i < 6; i++) begin
      lv = 6'h1 << i;
      cyc(2);
      rchk(4'h1, 32'hffff_ffff, 32'h1 << pos[i]);
    end
    lv = 6'h3f;
    cyc(2);
    rchk(4'h1, 32'h26, 32'h0);
    rchk(4'h2, 32'h6, 32'h0);
    lv = 6'h0;
  endtask
  task automatic t_ovf();
    pulse(ovf);
    cyc(1);
    rchk(4'h1, 32'h200, 32'h200);
    vicsr_host_i.wr(4'h1, 32'h0);
    rchk(4'h1, 32'h200, 32'h200);
    vicsr_host_i.wr(4'h1, 32'h200);
    rchk(4'h1, 32'h200, 32'h0);
  endtask
  task automatic t_irq();
    pulse(upd);
    cyc(2);
    rchk(4'h2, 32'h6, 32'h0);
    vicsr_host_i.wr(4'h0, 32'h2);
    pulse(upd);
    cyc(2);
    chk(irq, 1'h1);
    rchk(4'h2, 32'h6, 32'h2);
    vicsr_host_i.wr(4'h2, 32'h0);
    rchk(4'h2, 32'h6, 32'h2);
    vicsr_host_i.wr(4'h2, 32'h2);
    cyc(2);
    chk(irq, 1'h0);
    vicsr_host_i.wr(4'h0, 32'h4);
    lv = 6'h10;
    cyc(3);
    chk(irq, 1'h1);
    rchk(4'h2, 32'h6, 32'h4);
    vicsr_host_i.wr(4'h2, 32'h4);
    cyc(2);
    chk(irq, 1'h0);
    lv = 6'h0;
  endtask
  task automatic t_counts();
    used = 16'h0123;
    samp = 16'h0456;
    lines = 16'h0789;
    cyc(1);
    rchk(4'h3, 32'hffff_ffff, 32'h123);
    rchk(4'h4, 32'hffff_ffff, 32'h456);
    rchk(4'h5, 32'hffff_ffff, 32'h789);
    vicsr_host_i.wr(4'h3, 32'h0);
    rchk(4'h3, 32'hffff_ffff, 32'h123);
  endtask
  task automatic t_sync();
    sy = 3'h7;
    vicsr_host_i.wr(4'h0, 32'h0);
    cyc(2);
    chk({so, sl, rdiv}, 3'h0);
    vicsr_host_i.wr(4'h0, 32'h8);
    cyc(2);
    chk({so, sl, rdiv}, 3'h7);
    rchk(4'h0, 32'hf, 32'h8);
    sy = 3'h5;
    cyc(2);
    chk({so, sl, rdiv}, 3'h5);
  endtask
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  initial begin
    cyc(10);
    rst = 1'h0;
    t_reset();
    t_go();
    t_status();
    t_ovf();
    t_irq();
    t_counts();
    t_sync();
    results();
  end
endmodule

// >>> verification/vicsr_host.sv
`timescale 1ns/1ns
module vicsr_host (
  input wire logic sys_clk_i,
  input wire logic [31:0] av_readdata_i,
  output logic [3:0] av_address_o,
  output logic av_read_o,
  output logic av_write_o,
  output logic [31:0] av_writedata_o
);
  initial begin
    av_address_o = 4'hf;
    av_read_o = 1'h0;
    av_write_o = 1'h0;
    av_writedata_o = 32'h0;
  end
  // ------------------------------
  // One-word transfers, idle bus inverted
  // ------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    av_address_o = a;
    av_writedata_o = d;
    av_write_o = 1'h1;
    @(negedge sys_clk_i);
    av_write_o = 1'h0;
    av_address_o = ~a;
    av_writedata_o = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge sys_clk_i);
    av_address_o = a;
    av_read_o = 1'h1;
    @(negedge sys_clk_i);
    d = av_readdata_i;
    av_read_o = 1'h0;
    av_address_o = ~a;
  endtask
endmodule
